//--- hdl/ivm_defines.vh
`ifndef IVM_DEFINES_VH
`define IVM_DEFINES_VH

// ************************************************************
// widths and counts
// ************************************************************
`define IVM_ADDR_W 16
`define IVM_NUM_SRC 24
`define IVM_IDX_W 5
`define IVM_SRC_MASK_FULL 24'hffffff
`define IVM_SRC_MASK_SMALL 24'h3fffff

// ************************************************************
// reset vector and table layout
// ************************************************************
`define IVM_RESET_ADDR 16'h0000
`define IVM_RESET_NUM 5'h01
`define IVM_FIRST_IRQ_NUM 5'h02
`define IVM_BOOT_RESET_ADDR 16'h3800
`define IVM_FUSE_UNPROGRAMMED 1'b1

// ************************************************************
// interrupt vector table, base addresses
// ************************************************************
`define IVM_VEC_EXT_REQ0 16'h0002
`define IVM_VEC_PIN_CHG_A 16'h0004
`define IVM_VEC_PIN_CHG_B 16'h0006
`define IVM_VEC_TMR2_CMP 16'h0008
`define IVM_VEC_TMR2_OVF 16'h000a
`define IVM_VEC_TMR1_CAPT 16'h000c
`define IVM_VEC_TMR1_CMPA 16'h000e
`define IVM_VEC_TMR1_CMPB 16'h0010
`define IVM_VEC_TMR1_OVF 16'h0012
`define IVM_VEC_TMR0_CMP 16'h0014
`define IVM_VEC_TMR0_OVF 16'h0016
`define IVM_VEC_SPI_DONE 16'h0018
`define IVM_VEC_USART_RX 16'h001a
`define IVM_VEC_USART_TXE 16'h001c
`define IVM_VEC_USART_TX 16'h001e
`define IVM_VEC_SER_START 16'h0020
`define IVM_VEC_SER_OVF 16'h0022
`define IVM_VEC_ANA_CMP 16'h0024
`define IVM_VEC_CONV_DONE 16'h0026
`define IVM_VEC_NV_READY 16'h0028
`define IVM_VEC_PGM_READY 16'h002a
`define IVM_VEC_FRAME_START 16'h002c
`define IVM_VEC_PIN_CHG_C 16'h002e
`define IVM_VEC_PIN_CHG_D 16'h0030

// ************************************************************
// vector table select change sequence
// ************************************************************
`define IVM_CHG_WINDOW 3'h4
`define IVM_CHG_LAST 3'h0
`define IVM_CHG_STEP 3'h1

`endif

//--- hdl/ivm_prio_enc.v
`timescale 1ns/100ps
`default_nettype none

module ivm_prio_enc #(
    parameter WIDTH = 24,
    parameter IDX_W = 5
) (
    input wire [WIDTH-1:0] req_in,
    output wire any_out,
    output reg [IDX_W-1:0] idx_out
);

    // ************************************************************
    // lowest index wins
    // ************************************************************
    wire [WIDTH:0] lower_any;
    wire [WIDTH-1:0] grant;
    integer k;

    assign lower_any[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_chain
            assign grant[i] = req_in[i] & ~lower_any[i];
            assign lower_any[i+1] = lower_any[i] | req_in[i];
        end
    endgenerate

    assign any_out = lower_any[WIDTH];

    // grant is one-hot, so or-ing the indices gives the winner
    always @* begin
        idx_out = {IDX_W{1'b0}};
        for (k = 0; k < WIDTH; k = k + 1) begin
            if (grant[k]) begin
                idx_out = idx_out | k[IDX_W-1:0];
            end
        end
    end

endmodule // ivm_prio_enc

`default_nettype wire

//--- hdl/ivm_vector_map.v
// Behaviour
// - all reset causes share vector one
// - programmed fuse starts at boot address
// - fuse one unprogrammed, zero programmed
// - select bit adds boot start to vectors
// - fuse and select bit act independently
// - external and pin change a/b vectors
// - timer 2 overflow, timer 1 capture
// - timer 1 compare a/b and overflow
// - timer 0 compare and overflow
// - serial transfer and usart rx/empty vectors
// - usart tx and serial block vectors
// - comparator, converter, data memory vectors
// - program store and frame start vectors
// - pin change c/d removable by parameter
// - select changes only in timed sequence
// - change enable clears, interrupts blocked
`timescale 1ns/100ps
`default_nettype none
`include "ivm_defines.vh"

module ivm_vector_map #(
    parameter [15:0] BOOT_RESET_ADDR = `IVM_BOOT_RESET_ADDR,
    parameter EXTRA_PIN_CHANGE = 1
) (
    input wire CLK_IN,
    input wire RST_IN,
    input wire BOOT_RESET_FUSE_IN,
    input wire CTRL_WR_IN,
    input wire CTRL_SEL_IN,
    input wire CTRL_CHG_IN,
    input wire INSTR_DONE_IN,
    input wire [`IVM_NUM_SRC-1:0] IRQ_REQ_IN,
    input wire IRQ_ACK_IN,
    output reg [`IVM_ADDR_W-1:0] RESET_VECTOR_OUT,
    output reg VECTOR_TABLE_SELECT_OUT,
    output reg VECTOR_CHANGE_ENABLE_OUT,
    output reg IRQ_BLOCK_OUT,
    output reg IRQ_VALID_OUT,
    output reg [`IVM_ADDR_W-1:0] IRQ_VECTOR_OUT,
    output reg [`IVM_IDX_W-1:0] IRQ_NUM_OUT
);

    // ************************************************************
    // states of the select change sequence
    // ************************************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ARMED = 2'h1;
    localparam [1:0] ST_HOLD = 2'h2;

    localparam [`IVM_NUM_SRC-1:0] SRC_MASK =
        (EXTRA_PIN_CHANGE != 0) ? `IVM_SRC_MASK_FULL : `IVM_SRC_MASK_SMALL;

    // ************************************************************
    // decoding
    // ************************************************************
    function [`IVM_ADDR_W-1:0] reset_addr;
        input fuse;
        begin
            if (fuse == `IVM_FUSE_UNPROGRAMMED) begin
                reset_addr = `IVM_RESET_ADDR;
            end else begin
                reset_addr = BOOT_RESET_ADDR;
            end
        end
    endfunction

    function [`IVM_ADDR_W-1:0] vec_base;
        input [`IVM_IDX_W-1:0] idx;
        begin
            case (idx)
                5'h00: vec_base = `IVM_VEC_EXT_REQ0;
                5'h01: vec_base = `IVM_VEC_PIN_CHG_A;
                5'h02: vec_base = `IVM_VEC_PIN_CHG_B;
                5'h03: vec_base = `IVM_VEC_TMR2_CMP;
                5'h04: vec_base = `IVM_VEC_TMR2_OVF;
                5'h05: vec_base = `IVM_VEC_TMR1_CAPT;
                5'h06: vec_base = `IVM_VEC_TMR1_CMPA;
                5'h07: vec_base = `IVM_VEC_TMR1_CMPB;
                5'h08: vec_base = `IVM_VEC_TMR1_OVF;
                5'h09: vec_base = `IVM_VEC_TMR0_CMP;
                5'h0a: vec_base = `IVM_VEC_TMR0_OVF;
                5'h0b: vec_base = `IVM_VEC_SPI_DONE;
                5'h0c: vec_base = `IVM_VEC_USART_RX;
                5'h0d: vec_base = `IVM_VEC_USART_TXE;
                5'h0e: vec_base = `IVM_VEC_USART_TX;
                5'h0f: vec_base = `IVM_VEC_SER_START;
                5'h10: vec_base = `IVM_VEC_SER_OVF;
                5'h11: vec_base = `IVM_VEC_ANA_CMP;
                5'h12: vec_base = `IVM_VEC_CONV_DONE;
                5'h13: vec_base = `IVM_VEC_NV_READY;
                5'h14: vec_base = `IVM_VEC_PGM_READY;
                5'h15: vec_base = `IVM_VEC_FRAME_START;
                5'h16: vec_base = `IVM_VEC_PIN_CHG_C;
                5'h17: vec_base = `IVM_VEC_PIN_CHG_D;
                default: vec_base = `IVM_RESET_ADDR;
            endcase
        end
    endfunction

    // ************************************************************
    // fuse synchroniser
    // ************************************************************
    // not reset: the fuse is static, and holding reset three edges settles it
    reg fuse_meta;
    reg fuse_sync;

    always @(posedge CLK_IN) begin
        fuse_meta <= BOOT_RESET_FUSE_IN;
        fuse_sync <= fuse_meta;
    end

    // every reset cause lands here, the cause itself is not looked at
    always @(posedge CLK_IN) begin
        RESET_VECTOR_OUT <= reset_addr(fuse_sync);
    end

    // ************************************************************
    // select change sequence
    // ************************************************************
    reg [1:0] state;
    reg [2:0] chg_cnt;
    reg [1:0] next_state;
    reg [2:0] next_chg_cnt;
    reg next_sel;

    always @* begin
        next_state = state;
        next_chg_cnt = chg_cnt;
        next_sel = VECTOR_TABLE_SELECT_OUT;
        case (state)
            ST_IDLE: begin
                if (CTRL_WR_IN && CTRL_CHG_IN) begin
                    next_state = ST_ARMED;
                    next_chg_cnt = `IVM_CHG_WINDOW - `IVM_CHG_STEP;
                end
            end
            ST_ARMED: begin
                if (CTRL_WR_IN && CTRL_CHG_IN) begin
                    // a second arm restarts the window
                    next_chg_cnt = `IVM_CHG_WINDOW - `IVM_CHG_STEP;
                end else if (CTRL_WR_IN) begin
                    next_sel = CTRL_SEL_IN;
                    next_state = ST_HOLD;
                end else if (chg_cnt == `IVM_CHG_LAST) begin
                    next_state = ST_IDLE;
                end else begin
                    next_chg_cnt = chg_cnt - `IVM_CHG_STEP;
                end
            end
            ST_HOLD: begin
                if (CTRL_WR_IN && CTRL_CHG_IN) begin
                    next_state = ST_ARMED;
                    next_chg_cnt = `IVM_CHG_WINDOW - `IVM_CHG_STEP;
                end else if (INSTR_DONE_IN) begin
                    // the instruction after the select write has finished
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // a write outside the armed window leaves the select untouched
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            state <= ST_IDLE;
            chg_cnt <= 3'h0;
            VECTOR_TABLE_SELECT_OUT <= 1'b0;
            VECTOR_CHANGE_ENABLE_OUT <= 1'b0;
            IRQ_BLOCK_OUT <= 1'b0;
        end else begin
            state <= next_state;
            chg_cnt <= next_chg_cnt;
            VECTOR_TABLE_SELECT_OUT <= next_sel;
            VECTOR_CHANGE_ENABLE_OUT <= (next_state == ST_ARMED);
            IRQ_BLOCK_OUT <= (next_state != ST_IDLE);
        end
    end

    // ************************************************************
    // dispatch
    // ************************************************************
    wire [`IVM_NUM_SRC-1:0] req_live;
    wire req_any;
    wire [`IVM_IDX_W-1:0] req_idx;
    wire [`IVM_ADDR_W-1:0] base_addr;
    wire [`IVM_ADDR_W-1:0] moved_addr;

    assign req_live = IRQ_REQ_IN & SRC_MASK;

    ivm_prio_enc #(
        .WIDTH(`IVM_NUM_SRC),
        .IDX_W(`IVM_IDX_W)
    ) u_prio (
        .req_in(req_live),
        .any_out(req_any),
        .idx_out(req_idx)
    );

    assign base_addr = vec_base(req_idx);
    assign moved_addr = base_addr + BOOT_RESET_ADDR;

    // the cycle after an acknowledge shows nothing, giving the source time to drop
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            IRQ_VALID_OUT <= 1'b0;
            IRQ_VECTOR_OUT <= `IVM_RESET_ADDR;
            IRQ_NUM_OUT <= `IVM_RESET_NUM;
        end else begin
            IRQ_VALID_OUT <= req_any && (next_state == ST_IDLE) && !IRQ_ACK_IN;
            IRQ_NUM_OUT <= req_idx + `IVM_FIRST_IRQ_NUM;
            if (next_sel) begin
                IRQ_VECTOR_OUT <= moved_addr;
            end else begin
                IRQ_VECTOR_OUT <= base_addr;
            end
        end
    end

endmodule // ivm_vector_map

`default_nettype wire

//--- test/ivm_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// core sequencer model
// ********
module ivm_core_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic valid_in,
    input wire logic slow_in,
    output logic ack_out
);
    logic [1:0] wait_cnt;
    // slow mode lets a vector stand four cycles; ack is never two cycles running
    always @(posedge clk_in) begin
        if (rst_in || ack_out || !valid_in) begin
            ack_out <= 1'b0;
            wait_cnt <= 2'd0;
        end else begin
            wait_cnt <= wait_cnt + 2'd1;
            ack_out <= !slow_in || wait_cnt == 2'd3;
        end
    end
endmodule // ivm_core_model
`default_nettype wire

//--- test/ivm_vector_map_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "ivm_defines.vh"
// ********
// vector map checks
// ********
module ivm_vector_map_sva #(
    parameter [15:0] BOOT_RESET_ADDR = `IVM_BOOT_RESET_ADDR
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic BOOT_RESET_FUSE_IN,
    input wire logic CTRL_WR_IN,
    input wire logic CTRL_SEL_IN,
    input wire logic CTRL_CHG_IN,
    input wire logic [`IVM_NUM_SRC-1:0] IRQ_REQ_IN,
    input wire logic [`IVM_ADDR_W-1:0] RESET_VECTOR_OUT,
    input wire logic VECTOR_TABLE_SELECT_OUT,
    input wire logic VECTOR_CHANGE_ENABLE_OUT,
    input wire logic IRQ_BLOCK_OUT,
    input wire logic IRQ_VALID_OUT,
    input wire logic [`IVM_ADDR_W-1:0] IRQ_VECTOR_OUT,
    input wire logic [`IVM_IDX_W-1:0] IRQ_NUM_OUT
);
    logic [23:0] req_q;
    always @(posedge CLK_IN) req_q <= IRQ_REQ_IN;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    property p_rst_app;
        $past(BOOT_RESET_FUSE_IN, 3) |-> RESET_VECTOR_OUT == 16'h0;
    endproperty
    a_rst_app: assert property (p_rst_app) else $error("app reset vector");
    property p_rst_boot;
        !$past(BOOT_RESET_FUSE_IN, 3) |-> RESET_VECTOR_OUT == BOOT_RESET_ADDR;
    endproperty
    a_rst_boot: assert property (p_rst_boot) else $error("boot reset vector");
    property p_vec;
        IRQ_VALID_OUT |-> IRQ_VECTOR_OUT == {10'h0, IRQ_NUM_OUT, 1'b0} - 16'h2
            + (VECTOR_TABLE_SELECT_OUT ? BOOT_RESET_ADDR : 16'h0);
    endproperty
    a_vec: assert property (p_vec) else $error("vector address");
    // lowest set request wins; every lower bit must have been clear
    property p_prio;
        IRQ_VALID_OUT |-> req_q[IRQ_NUM_OUT - 5'd2]
            && (req_q & ((24'h1 << (IRQ_NUM_OUT - 5'd2)) - 24'h1)) == 24'h0;
    endproperty
    a_prio: assert property (p_prio) else $error("priority");
    property p_arm;
        CTRL_WR_IN && CTRL_CHG_IN |=> VECTOR_CHANGE_ENABLE_OUT && IRQ_BLOCK_OUT && !IRQ_VALID_OUT;
    endproperty
    a_arm: assert property (p_arm) else $error("arm");
    property p_expire;
        $rose(VECTOR_CHANGE_ENABLE_OUT) ##0 !CTRL_WR_IN [*4]
            |=> !VECTOR_CHANGE_ENABLE_OUT && !IRQ_BLOCK_OUT;
    endproperty
    a_expire: assert property (p_expire) else $error("window expiry");
    property p_hold_sel;
        !VECTOR_CHANGE_ENABLE_OUT |=> $stable(VECTOR_TABLE_SELECT_OUT);
    endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("select moved");
    property p_sel_wr;
        VECTOR_CHANGE_ENABLE_OUT && CTRL_WR_IN && !CTRL_CHG_IN |=>
            VECTOR_TABLE_SELECT_OUT == $past(CTRL_SEL_IN) && !VECTOR_CHANGE_ENABLE_OUT;
    endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("select write");
endmodule // ivm_vector_map_sva
`default_nettype wire

//--- test/ivm_vector_map_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ivm_defines.vh"
// ********
// bench top
// ********
module ivm_vector_map_tb;
    logic clk = 0, rst = 1, fuse = 1, wr = 0, sel = 0, chg = 0, done = 0, slow = 0, cur = 0;
    logic [23:0] req = 0;
    logic [31:0] lfsr = 32'h3291;
    logic [15:0] rvec, vec, vec_s, exp_vec, exp_base;
    logic [4:0] num;
    logic tsel, ten, blk, vld, ack, vld_s;
    logic [15:0] expq[$];
    int failures = 0, check_count = 0;
    always #2 clk = ~clk;
    ivm_vector_map dut (.CLK_IN(clk), .RST_IN(rst), .BOOT_RESET_FUSE_IN(fuse), .CTRL_WR_IN(wr),
        .CTRL_SEL_IN(sel), .CTRL_CHG_IN(chg), .INSTR_DONE_IN(done), .IRQ_REQ_IN(req),
        .IRQ_ACK_IN(ack), .RESET_VECTOR_OUT(rvec), .VECTOR_TABLE_SELECT_OUT(tsel),
        .VECTOR_CHANGE_ENABLE_OUT(ten), .IRQ_BLOCK_OUT(blk), .IRQ_VALID_OUT(vld),
        .IRQ_VECTOR_OUT(vec), .IRQ_NUM_OUT(num));
    // variant without the two extra pin change sources, never acked, so it mirrors the request
    ivm_vector_map #(.EXTRA_PIN_CHANGE(0)) dut_small (.CLK_IN(clk), .RST_IN(rst),
        .BOOT_RESET_FUSE_IN(fuse), .CTRL_WR_IN(wr), .CTRL_SEL_IN(sel), .CTRL_CHG_IN(chg),
        .INSTR_DONE_IN(done), .IRQ_REQ_IN(req), .IRQ_ACK_IN(1'b0), .RESET_VECTOR_OUT(),
        .VECTOR_TABLE_SELECT_OUT(), .VECTOR_CHANGE_ENABLE_OUT(), .IRQ_BLOCK_OUT(),
        .IRQ_VALID_OUT(vld_s), .IRQ_VECTOR_OUT(vec_s), .IRQ_NUM_OUT());
    ivm_core_model core (.clk_in(clk), .rst_in(rst), .valid_in(vld), .slow_in(slow), .ack_out(ack));
    function automatic logic [31:0] step(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(string what, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset(logic f);
        rst = 1;
        fuse = f;
        cur = 0;
        tick(16);
        rst = 0;
    endtask
    // idle cycle after each write so back-to-back calls never retouch wr in one step
    task automatic ctl(logic c, logic s);
        wr = 1;
        chg = c;
        sel = s;
        tick(1);
        wr = 0;
        tick(1);
    endtask
    // served in ascending source order, since the lowest set source wins and drops once acked
    task automatic fire(logic [23:0] r, logic held);
        int n;
        for (n = 0; n < 24; n++)
            if (r[n]) expq.push_back(16'(2 * n + 2) + (cur ? `IVM_BOOT_RESET_ADDR : 16'h0));
        req = r;
        if (held) begin
            tick(4);
            chk("valid while blocked", 16'h0, {15'h0, vld});
            chk("block", 16'h1, {15'h0, blk});
            chk("change enable", 16'h0, {15'h0, ten});
            done = 1;
            tick(1);
            done = 0;
        end
        for (n = 0; n < 400 && (req != 0 || expq.size() != 0); n++) tick(1);
        if (n == 400) begin
            failures++;
            end_sim;
        end
    endtask
    always @(posedge clk) begin
        if (vld === 1'b1 && ack === 1'b1) begin
            exp_vec = expq.size() != 0 ? expq.pop_front() : 16'hffff;
            exp_base = exp_vec - (cur ? `IVM_BOOT_RESET_ADDR : 16'h0);
            chk("vector", exp_vec, vec);
            chk("number", (exp_base >> 1) + 16'h1, {11'h0, num});
            chk("small valid", {15'h0, exp_base < 16'h002e}, {15'h0, vld_s});
            if (exp_base < 16'h002e) chk("small vector", exp_vec, vec_s);
            req[num - 5'd2] <= 1'b0;
        end
    end
    initial begin
        for (int f = 1; f >= 0; f--) begin
            for (int s = 0; s < 2; s++) begin
                do_reset(f[0]);
                chk("reset vector", f ? 16'h0 : `IVM_BOOT_RESET_ADDR, rvec);
                if (s) begin
                    ctl(1, 0);
                    ctl(0, 1);
                    cur = 1;
                    fire(24'h0, 1);
                end
                chk("select", {15'h0, cur}, {15'h0, tsel});
                for (int i = 0; i < 24; i++) fire(24'h1 << i, 0);
                $display("placement fuse %0d select %0d done", f, s);
            end
        end
        slow = 1;
        repeat (20) begin
            lfsr = step(lfsr);
            fire(lfsr[23:0], 0);
        end
        $display("random priority done");
        ctl(0, 0);
        chk("unarmed write", 16'h1, {15'h0, tsel});
        ctl(1, 0);
        tick(5);
        ctl(0, 0);
        chk("late write", 16'h1, {15'h0, tsel});
        ctl(1, 0);
        ctl(0, 0);
        cur = 0;
        fire(24'h10, 1);
        chk("select", 16'h0, {15'h0, tsel});
        $display("change sequence done");
        end_sim;
    end
endmodule // ivm_vector_map_tb
bind ivm_vector_map ivm_vector_map_sva #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) u_sva (.*);
`default_nettype wire
